// ===== pkg/ref_clock_defs.svh
// constants for the reference clock select and monitor block
// assumes a 10 MHz system clock; included by bare name
`ifndef REF_CLOCK_DEFS_SVH
`define REF_CLOCK_DEFS_SVH
`define SRC_INTERNAL     2'h0
`define SRC_EXTERNAL     2'h1
`define SRC_SYNC_LINK    2'h2
`define LOCK_LOCKED      2'h0
`define LOCK_ERROR       2'h1
`define LOCK_BUSY        2'h2
`define CLK_SYS_HZ       10000000
`define GATE_TIME_MS     1
`define GATE_CYCLES      (`CLK_SYS_HZ / 1000 * `GATE_TIME_MS)
`define GATE_CNT_W       14
`define FREQ_W           24
`define FREQ_SCALE_HZ    1000
`define OUT_10MHZ        1'h0
`define OUT_100MHZ       1'h1
`define LOCK_TIMEOUT_MS  2
`define LOCK_TIMEOUT_CYC (`CLK_SYS_HZ / 1000 * `LOCK_TIMEOUT_MS)
`define LOCK_CNT_W       16
`define LOCK_MIN_EDGES   24'h0003e8
`define REF_10M_KHZ      24'h002710
`define REF_100M_KHZ     24'h0186a0
`define REF_TOL_KHZ      24'h000064
`endif

// ===== pkg/ref_clock_pkg.sv
// types for the reference clock select and monitor block
// assumes ref_clock_defs.svh holds the numeric constants
package ref_clock_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOCK = 3'b010,
        ST_HOLD = 3'b100
    } lock_state_e;
endpackage

// ===== rtl/edge_counter.sv
// gated edge counter for the reference input frequency
// assumes the sampled input is already synchronised to clk_sys
`timescale 1ns/10ps
`include "ref_clock_defs.svh"
module edge_counter (
    input  wire logic                 clk_sys,   // system clock
    input  wire logic                 rst_b,     // sync reset, active low
    input  wire logic                 ref_sync,  // synchronised reference level
    output logic [`FREQ_W-1:0]        edges_ff,  // edges in the last gate window
    output logic                      done_ff    // pulse at end of each window
);
    logic [`GATE_CNT_W-1:0] gate_ff;
    logic [`FREQ_W-1:0]     run_ff;
    logic                   prev_ff;
    logic                   rise;

    assign rise = ref_sync & ~prev_ff;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            prev_ff  <= 1'h0;
            gate_ff  <= '0;
            run_ff   <= '0;
            edges_ff <= '0;
            done_ff  <= 1'h0;
        end else begin
            prev_ff <= ref_sync;
            done_ff <= 1'h0;
            if (gate_ff == `GATE_CNT_W'(`GATE_CYCLES - 1)) begin
                gate_ff  <= '0;
                edges_ff <= run_ff + `FREQ_W'(rise);
                run_ff   <= '0;
                done_ff  <= 1'h1;
            end else begin
                gate_ff <= gate_ff + `GATE_CNT_W'(1);
                run_ff  <= run_ff + `FREQ_W'(rise);
            end
        end
    end
endmodule

// ===== rtl/ref_clock_ctrl.sv
// reference source select, lock status, frequency readback, clock output
// assumes reference pins are sampled at 10 MHz; real rates are seen aliased,
// so lock checks only that the input shows at least LOCK_MIN_EDGES (1000) rising edges within the gate window
`timescale 1ns/10ps
`include "ref_clock_defs.svh"
module ref_clock_ctrl (
    input  wire logic        clk_sys,          // system clock, 10 MHz
    input  wire logic        rst_b,            // sync reset, active low
    input  wire logic [1:0]  src_sel,          // intended source
    input  wire logic        out_en,           // reference output enable
    input  wire logic        out_freq_sel,     // 0 10 MHz, 1 100 MHz
    input  wire logic        ext_ref_in,       // external reference pin
    input  wire logic        sync_ref_in,      // sync link clock pin
    output logic [1:0]       src_actual_ff,    // source in use
    output logic [1:0]       lock_status_ff,   // lock status code
    output logic [23:0]      freq_khz_ff,      // measured input, kHz
    output logic             ref_out_ff,       // reference clock output
    output logic             ref_out_freq_ff,  // frequency in effect
    output logic             link_drop_ff      // one-cycle drop of sync links
);
    logic [1:0]              ext_sync_ff;
    logic [1:0]              link_sync_ff;
    logic [1:0]              src_prev_ff;
    logic                    en_prev_ff;
    logic [1:0]              target_ff;
    logic [`LOCK_CNT_W-1:0]  lock_cnt_ff;
    logic                    ref_sel;
    logic [`FREQ_W-1:0]      edges;
    logic                    gate_done;
    logic                    src_change;
    logic                    en_change;
    logic                    in_tol;
    ref_clock_pkg::lock_state_e state_ff;

    // two-stage synchronisers; only stage 2 is read by logic
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ext_sync_ff  <= 2'h0;
            link_sync_ff <= 2'h0;
        end else begin
            ext_sync_ff  <= {ext_sync_ff[0], ext_ref_in};
            link_sync_ff <= {link_sync_ff[0], sync_ref_in};
        end
    end

    assign ref_sel = (target_ff == `SRC_SYNC_LINK) ? link_sync_ff[1] : ext_sync_ff[1];

    edge_counter u_edge_counter (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .ref_sync (ref_sel),
        .edges_ff (edges),
        .done_ff  (gate_done)
    );

    // measured frequency; edges per window scaled to kHz
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            freq_khz_ff <= '0;
        end else if (gate_done) begin
            freq_khz_ff <= `FREQ_W'(edges / `GATE_TIME_MS);
        end
    end

    // a selection outside 0..2 is treated as internal
    assign src_change = (src_sel != src_prev_ff);
    assign en_change  = (out_en != en_prev_ff);
    assign in_tol     = (edges >= `LOCK_MIN_EDGES);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            src_prev_ff  <= `SRC_INTERNAL;
            en_prev_ff   <= 1'h0;
            link_drop_ff <= 1'h0;
        end else begin
            src_prev_ff  <= src_sel;
            en_prev_ff   <= out_en;
            link_drop_ff <= src_change | en_change;
        end
    end

    // lock sequencer
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_ff       <= ref_clock_pkg::ST_IDLE;
            target_ff      <= `SRC_INTERNAL;
            src_actual_ff  <= `SRC_INTERNAL;
            lock_status_ff <= `LOCK_LOCKED;
            lock_cnt_ff    <= '0;
        end else if (src_change) begin
            target_ff      <= (src_sel > `SRC_SYNC_LINK) ? `SRC_INTERNAL : src_sel;
            lock_status_ff <= `LOCK_BUSY;
            lock_cnt_ff    <= '0;
            state_ff       <= ref_clock_pkg::ST_LOCK;
        end else begin
            case (state_ff)
                ref_clock_pkg::ST_IDLE: begin
                    state_ff <= ref_clock_pkg::ST_IDLE;
                end
                ref_clock_pkg::ST_LOCK: begin
                    if (target_ff == `SRC_INTERNAL) begin
                        src_actual_ff  <= `SRC_INTERNAL;
                        lock_status_ff <= `LOCK_LOCKED;
                        state_ff       <= ref_clock_pkg::ST_HOLD;
                    end else if (gate_done && in_tol) begin
                        src_actual_ff  <= target_ff;
                        lock_status_ff <= `LOCK_LOCKED;
                        state_ff       <= ref_clock_pkg::ST_HOLD;
                    end else if (lock_cnt_ff == `LOCK_CNT_W'(`LOCK_TIMEOUT_CYC - 1)) begin
                        // fall back to the internal base on failure
                        src_actual_ff  <= `SRC_INTERNAL;
                        lock_status_ff <= `LOCK_ERROR;
                        state_ff       <= ref_clock_pkg::ST_HOLD;
                    end else begin
                        lock_cnt_ff <= lock_cnt_ff + `LOCK_CNT_W'(1);
                    end
                end
                ref_clock_pkg::ST_HOLD: begin
                    // loss of an external reference after lock is an error
                    if (target_ff != `SRC_INTERNAL && gate_done && !in_tol
                        && lock_status_ff == `LOCK_LOCKED) begin
                        src_actual_ff  <= `SRC_INTERNAL;
                        lock_status_ff <= `LOCK_ERROR;
                    end
                end
                default: begin
                    state_ff <= ref_clock_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // output: 100 MHz cannot be built from a 10 MHz clock, so the pin
    // carries a divided marker and ref_out_freq_ff tells the PLL which rate
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ref_out_ff      <= 1'h0;
            ref_out_freq_ff <= `OUT_10MHZ;
        end else begin
            ref_out_freq_ff <= out_freq_sel ? `OUT_100MHZ : `OUT_10MHZ;
            if (out_en && !en_change) begin
                ref_out_ff <= ~ref_out_ff;
            end else begin
                ref_out_ff <= 1'h0;
            end
        end
    end
endmodule

// ===== verification/ref_clock_ctrl_properties.sv
// port checker for the reference clock select block
// assumes bind onto ref_clock_ctrl, single clk_sys domain
`timescale 1ns/10ps
module ref_clock_ctrl_checker (
    input wire logic        clk_sys,         // clock
    input wire logic        rst_b,           // reset
    input wire logic [1:0]  src_sel,         // intended
    input wire logic        out_en,          // out enable
    input wire logic        out_freq_sel,    // out rate
    input wire logic        ext_ref_in,      // ext ref
    input wire logic        sync_ref_in,     // link clk
    input wire logic [1:0]  src_actual_ff,   // in use
    input wire logic [1:0]  lock_status_ff,  // status
    input wire logic [23:0] freq_khz_ff,     // freq
    input wire logic        ref_out_ff,      // ref out
    input wire logic        ref_out_freq_ff, // rate out
    input wire logic        link_drop_ff     // drop
);
    logic [1:0] src_q;
    logic       en_q;
    wire        chg = src_sel != src_q;
    // mirrors the design's own history so a release with nonzero select counts
    always_ff @(posedge clk_sys) begin
        src_q <= rst_b ? src_sel : 2'h0;
        en_q  <= rst_b ? out_en : 1'b0;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_drop_on_change: assert property (chg || out_en != en_q |=> link_drop_ff)
        else $error("missing drop pulse");
    a_no_stray_drop: assert property (!chg && out_en == en_q |=> !link_drop_ff)
        else $error("stray drop pulse");
    a_busy_after_src: assert property (chg |=> lock_status_ff == 2'h2)
        else $error("not busy after change");
    a_internal_lock: assert property (chg && src_sel == 2'h0 ##1 src_sel == 2'h0
        |=> lock_status_ff == 2'h0 && src_actual_ff == 2'h0) else $error("internal lock");
    a_status_code: assert property (lock_status_ff != 2'h3)
        else $error("bad status code");
    a_actual_code: assert property (src_actual_ff != 2'h3)
        else $error("bad actual code");
    a_out_quiet: assert property (!out_en && !en_q |=> !ref_out_ff)
        else $error("output not quiet");
    a_out_toggle: assert property (out_en [*3] |=> $changed(ref_out_ff))
        else $error("output not toggling");
    a_rate_follow: assert property (1'b1 |=> ref_out_freq_ff == $past(out_freq_sel))
        else $error("rate not followed");
    c_err: cover property (lock_status_ff == 2'h1);
    c_ext: cover property (src_actual_ff == 2'h1 && lock_status_ff == 2'h0);
    c_drop: cover property (link_drop_ff);
endmodule

// ===== verification/ref_source_model.sv
// far-side reference generator and sync link clock
// assumes bench on/off controls; a stopped line idles low
`timescale 1ns/10ps
module ref_source_model #(
    parameter int HALF_NS = 200  // half period of the reference
) (
    input  wire logic ext_on,      // generator running
    input  wire logic sync_on,     // link clock running
    output logic      ext_ref_in,  // reference line
    output logic      sync_ref_in  // link clock line
);
    // true 10/100 mhz aliases on a 10 mhz sampler, so a visible rate stands in
    initial ext_ref_in = 1'b0;
    initial sync_ref_in = 1'b0;
    always #(HALF_NS) ext_ref_in = ext_on ? ~ext_ref_in : 1'b0;
    always #(HALF_NS - 27) sync_ref_in = sync_on ? ~sync_ref_in : 1'b0;
endmodule

// ===== verification/ref_clock_ctrl_tb.sv
// self-checking bench for ref_clock_ctrl
// assumes checker and source model compiled first
`timescale 1ns/10ps
module ref_clock_ctrl_tb;
    localparam int HALF = 200;
    logic        clk_sys = 1'b0;
    logic        rst_b, out_en, out_freq_sel, ext_on, sync_on, ext_ref_in, sync_ref_in;
    logic [1:0]  src_sel;
    wire  [1:0]  src_actual_ff, lock_status_ff;
    wire  [23:0] freq_khz_ff;
    wire         ref_out_ff, ref_out_freq_ff, link_drop_ff;
    int          error_cnt = 0;
    int          check_count = 0;
    int          seed = 32'hbaae;
    int          exp_src, exp_lock, n, i;
    logic        fsel;
    always #50 clk_sys = ~clk_sys;
    ref_source_model #(.HALF_NS(HALF)) i_src (.ext_on(ext_on), .sync_on(sync_on),
        .ext_ref_in(ext_ref_in), .sync_ref_in(sync_ref_in));
    ref_clock_ctrl i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .src_sel(src_sel),
        .out_en(out_en), .out_freq_sel(out_freq_sel), .ext_ref_in(ext_ref_in),
        .sync_ref_in(sync_ref_in), .src_actual_ff(src_actual_ff),
        .lock_status_ff(lock_status_ff), .freq_khz_ff(freq_khz_ff), .ref_out_ff(ref_out_ff),
        .ref_out_freq_ff(ref_out_freq_ff), .link_drop_ff(link_drop_ff));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys);
        #5;
    endtask
    task automatic run_src(input logic [1:0] s);
        src_sel = s;
        step(1);
        chk(link_drop_ff, 1, "drop");
        chk(lock_status_ff, 2, "busy");
        chk(src_actual_ff, 24'(exp_src), "early actual");
        for (n = 0; lock_status_ff === 2'h2 && n < 25000; n++) step(1);
        exp_lock = (s == 0 || (s == 1 ? ext_on : sync_on)) ? 0 : 1;
        exp_src = exp_lock == 0 ? s : 0;
        if (s == 0) chk(24'(n), 1, "internal lock time");
        chk(lock_status_ff, 24'(exp_lock), "lock");
        chk(src_actual_ff, 24'(exp_src), "actual");
        $display("test source %0d done", s);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        rst_b = 1'b0; src_sel = 2'h0; out_en = 1'b0; out_freq_sel = 1'b0;
        ext_on = 1'b0; sync_on = 1'b0; exp_src = 0;
        step(6);
        rst_b = 1'b1;
        chk({src_actual_ff, lock_status_ff, ref_out_ff, link_drop_ff}, 0, "reset");
        ext_on = 1'b1;
        run_src(2'h1);
        step(10001);
        n = 1000000 / (2 * HALF);
        chk(24'(freq_khz_ff >= n - 1 && freq_khz_ff <= n + 1), 1, "freq");
        run_src(2'h2);
        sync_on = 1'b1;
        run_src(2'h0);
        run_src(2'h2);
        out_en = 1'b1;
        step(1);
        chk(link_drop_ff, 1, "drop on enable");
        chk(ref_out_ff, 0, "output early");
        step(1);
        chk(ref_out_ff, 1, "output on");
        for (i = 0; i < 8; i++) begin
            fsel = 1'($random(seed));
            out_freq_sel = fsel;
            step(1);
            chk(ref_out_freq_ff, fsel, "rate");
            chk(ref_out_ff, i[0], "toggle");
        end
        out_en = 1'b0;
        step(1);
        chk(link_drop_ff, 1, "drop on disable");
        step(2);
        chk(ref_out_ff, 0, "output quiet");
        $display("test output done");
        wrap_up;
    end
    initial begin
        #(100 * 95000);
        error_cnt++;
        wrap_up;
    end
endmodule
bind ref_clock_ctrl ref_clock_ctrl_checker i_chk (.clk_sys(clk_sys), .rst_b(rst_b),
    .src_sel(src_sel), .out_en(out_en), .out_freq_sel(out_freq_sel),
    .ext_ref_in(ext_ref_in), .sync_ref_in(sync_ref_in), .src_actual_ff(src_actual_ff),
    .lock_status_ff(lock_status_ff), .freq_khz_ff(freq_khz_ff), .ref_out_ff(ref_out_ff),
    .ref_out_freq_ff(ref_out_freq_ff), .link_drop_ff(link_drop_ff));
